// File: pkg/charger_pkg.sv
// Constants shared by the battery charge controller.
// Assumes measurement codes arrive already synchronous to the 20 MHz clock.
package charger_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLOCK_HZ            = 20_000_000;
	localparam int          RETRY_MS            = 500;
	localparam int          RETRY_CYCLES        = CLOCK_HZ / 1000 * RETRY_MS;
	localparam int          TRICKLE_MIN         = 10;
	localparam longint      TRICKLE_CYCLES      = longint'(CLOCK_HZ) * 60 * TRICKLE_MIN;
	localparam int          SAFETY_HOURS        = 7;
	localparam longint      SAFETY_CYCLES       = longint'(CLOCK_HZ) * 3600 * SAFETY_HOURS;

	// ------------------------------------------------------------
	// Charge current code (mA / 2)
	// ------------------------------------------------------------
	localparam int          CURRENT_W           = 9;
	localparam logic [8:0]  CURRENT_MIN_CODE    = 9'h010;
	localparam logic [8:0]  CURRENT_MAX_CODE    = 9'h190;
	localparam logic [7:0]  CURRENT_HIGH_RESET  = 8'h08;
	localparam logic        CURRENT_LOW_RESET   = 1'b0;

	// ------------------------------------------------------------
	// Thermistor and die temperature codes
	// ------------------------------------------------------------
	localparam int          CODE_W              = 10;
	localparam logic [9:0]  NTC_COLD_RESET      = 10'h2ed;
	localparam logic [9:0]  NTC_COOL_RESET      = 10'h292;
	localparam logic [9:0]  NTC_WARM_RESET      = 10'h151;
	localparam logic [9:0]  NTC_HOT_RESET       = 10'h0ed;
	localparam logic [9:0]  DIE_STOP_RESET      = 10'h167;
	localparam logic [9:0]  DIE_RESUME_RESET    = 10'h174;

	// ------------------------------------------------------------
	// Voltages in mV, recharge percentage
	// ------------------------------------------------------------
	localparam int          MV_W                = 13;
	localparam logic [12:0] TRICKLE_EXIT_RESET  = 13'h0b54;
	localparam int          RECHARGE_PCT        = 95;

	typedef enum logic [1:0] {
		ZONE_COLD_HOT = 2'h0,
		ZONE_COOL     = 2'h1,
		ZONE_NOMINAL  = 2'h2,
		ZONE_WARM     = 2'h3
	} zone_t;

	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_DETECT  = 7'h02,
		ST_TRICKLE = 7'h04,
		ST_CC      = 7'h08,
		ST_CV      = 7'h10,
		ST_DONE    = 7'h20,
		ST_ERROR   = 7'h40
	} charge_state_t;

endpackage

// File: core/temp_zone.sv
// Battery temperature zone classifier.
// Assumes thresholds are programmed cold >= cool >= warm >= hot in code terms.
`timescale 1ns/10ps
`default_nettype none
module temp_zone
	import charger_pkg::*;
#(
	parameter int W = CODE_W
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Measurement and thresholds
	input  wire logic [W-1:0] ntc_code,
	input  wire logic [W-1:0] cold_code,
	input  wire logic [W-1:0] cool_code,
	input  wire logic [W-1:0] warm_code,
	input  wire logic [W-1:0] hot_code,
	input  wire logic         monitor_off,
	// Results
	output zone_t             zone,
	output logic              crossing
);
	// Higher temperature gives a lower code.
	wire logic is_cold = ntc_code > cold_code;
	wire logic is_hot  = ntc_code < hot_code;
	wire logic is_cool = ntc_code > cool_code;
	wire logic is_warm = ntc_code < warm_code;
	zone_t     next_zone;

	assign next_zone = monitor_off          ? ZONE_NOMINAL :
	                   (is_cold || is_hot)  ? ZONE_COLD_HOT :
	                   is_cool              ? ZONE_COOL :
	                   is_warm              ? ZONE_WARM : ZONE_NOMINAL;

	// Any zone change marks a threshold crossing.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			zone     <= ZONE_NOMINAL;
			crossing <= 1'b0;
		end else begin
			zone     <= next_zone;
			crossing <= (next_zone != zone);
		end
	end
endmodule
`default_nettype wire

// File: core/battery_charge_controller.sv
// Charge sequencing for a linear battery charger.
// Assumes voltages, currents and temperature codes come synchronous from an ADC.
// Summary of operation
// - Charging starts only with enable set, supply present and battery detected.
// - Trickle first after detection, constant current once above trickle exit.
// - Constant voltage at termination voltage; done when current below termination.
// - After done, wait for battery below recharge threshold before new cycle.
// - Lockout release retried every 500 ms while it fails.
// - Battery-present flag shows faulty or missing battery.
// - Reset clears charge control bits; charging disabled.
// - Charge current 32 to 800 mA in 2 mA steps, default 32 mA.
// - 9-bit code mA/2; high eight bits and low bit separate.
// - New current takes effect only when charging is next enabled.
// - Trickle charges at tenth of current below trickle exit, default 2.9 V.
// - Termination current selectable ten or twenty percent.
// - No charging when cold or hot; optional pause at warm.
// - Thermistor thresholds are 10-bit codes, cold 749 and hot 237 default.
// - Cool region charges half current outside trickle unless reduction disabled.
// - Warm region uses warm termination voltage, others normal.
// - Interrupt on battery temperature threshold crossings.
// - Stop charging at die stop limit, resume at resume limit.
// - Die limits are 10-bit codes; lower code means hotter.
// - Status flag shows die temperature above stop limit.
// - Recharge threshold is 95 percent of termination voltage.
// - Automatic recharge unless disabled, with interrupt.
// - Trickle timeout or safety timer expiry disables charging with error.
`timescale 1ns/10ps
`default_nettype none
module battery_charge_controller
	import charger_pkg::*;
#(
	parameter int     CW              = CURRENT_W,
	parameter int     RETRY_TICKS     = RETRY_CYCLES,
	parameter longint TRICKLE_TICKS   = TRICKLE_CYCLES,
	parameter longint SAFETY_TICKS    = SAFETY_CYCLES
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Control strobes
	input  wire logic              charge_enable_set,
	input  wire logic              charge_enable_clear,
	input  wire logic              feature_disable_set,
	input  wire logic              recharge_disable_in,
	input  wire logic              ntc_disable_in,
	input  wire logic              release_error,
	input  wire logic              clear_safety_timer,
	// Configuration
	input  wire logic              charger_config,
	input  wire logic              cool_full_current,
	input  wire logic              term_current_20,
	input  wire logic [7:0]        charge_current_high,
	input  wire logic              charge_current_low,
	input  wire logic              current_write,
	input  wire logic [MV_W-1:0]   term_voltage,
	input  wire logic [MV_W-1:0]   warm_term_voltage,
	input  wire logic [MV_W-1:0]   trickle_exit_voltage,
	input  wire logic              trickle_exit_write,
	input  wire logic [CODE_W-1:0] ntc_thr_cold,
	input  wire logic [CODE_W-1:0] ntc_thr_cool,
	input  wire logic [CODE_W-1:0] ntc_thr_warm,
	input  wire logic [CODE_W-1:0] ntc_thr_hot,
	input  wire logic              ntc_thr_write,
	input  wire logic [CODE_W-1:0] die_stop_temp,
	input  wire logic [CODE_W-1:0] die_resume_temp,
	input  wire logic              die_thr_write,
	// Analog side
	input  wire logic              supply_present,
	input  wire logic              battery_sensed,
	input  wire logic              undervoltage_lockout,
	input  wire logic [MV_W-1:0]   battery_mv,
	input  wire logic [CW+1:0]     battery_current,
	input  wire logic [CODE_W-1:0] ntc_code,
	input  wire logic [CODE_W-1:0] die_code,
	// Outputs to analog side
	output logic                   charge_on,
	output logic [CW-1:0]          charge_current_code,
	output logic [MV_W-1:0]        target_voltage,
	output logic                   release_attempt,
	// Status
	output logic                   battery_present,
	output logic                   die_temp_status_a,
	output logic                   charging_active,
	output logic                   charge_error,
	output charge_state_t          charge_state,
	output logic                   temp_event,
	output logic                   recharge_event,
	output logic                   die_event,
	output logic                   done_event
);
	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic              enabled;
	logic              recharge_off;
	logic              ntc_off;
	logic [CW-1:0]     current_reg;
	logic [CW-1:0]     current_live;
	logic [MV_W-1:0]   trickle_exit;
	logic [CODE_W-1:0] thr_cold, thr_cool, thr_warm, thr_hot;
	logic [CODE_W-1:0] die_stop, die_resume;
	logic              die_hot;
	logic [31:0]       retry_count;
	logic [63:0]       timer;
	charge_state_t     next_state;
	zone_t             zone;
	logic              zone_cross;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			enabled      <= 1'b0;
			recharge_off <= 1'b0;
			ntc_off      <= 1'b0;
			current_reg  <= {CURRENT_HIGH_RESET, CURRENT_LOW_RESET};
			trickle_exit <= TRICKLE_EXIT_RESET;
			thr_cold     <= NTC_COLD_RESET;
			thr_cool     <= NTC_COOL_RESET;
			thr_warm     <= NTC_WARM_RESET;
			thr_hot      <= NTC_HOT_RESET;
			die_stop     <= DIE_STOP_RESET;
			die_resume   <= DIE_RESUME_RESET;
		end else begin
			if (charge_enable_set)
				enabled <= 1'b1;
			else if (charge_enable_clear || next_state == ST_ERROR)
				enabled <= 1'b0;
			if (feature_disable_set) begin
				recharge_off <= recharge_disable_in;
				ntc_off      <= ntc_disable_in;
			end
			if (current_write)
				current_reg <= {charge_current_high, charge_current_low};
			if (trickle_exit_write)
				trickle_exit <= trickle_exit_voltage;
			if (ntc_thr_write) begin
				thr_cold <= ntc_thr_cold;
				thr_cool <= ntc_thr_cool;
				thr_warm <= ntc_thr_warm;
				thr_hot  <= ntc_thr_hot;
			end
			if (die_thr_write) begin
				die_stop   <= die_stop_temp;
				die_resume <= die_resume_temp;
			end
		end
	end

	// ------------------------------------------------------------
	// Current setting and clamping
	// ------------------------------------------------------------
	// clamp to legal range
	wire logic [CW-1:0] current_clamped =
		(current_reg < CURRENT_MIN_CODE[CW-1:0]) ? CURRENT_MIN_CODE[CW-1:0] :
		(current_reg > CURRENT_MAX_CODE[CW-1:0]) ? CURRENT_MAX_CODE[CW-1:0] : current_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			current_live <= CURRENT_MIN_CODE[CW-1:0];
		else if (charge_enable_set && !enabled)
			current_live <= current_clamped;
	end

	// ------------------------------------------------------------
	// Temperature zones and die regulation
	// ------------------------------------------------------------
	// monitoring may be off
	temp_zone #(
		.W (CODE_W)
	) u_zone (
		.clock       (clock),
		.rst         (rst),
		.ntc_code    (ntc_code),
		.cold_code   (thr_cold),
		.cool_code   (thr_cool),
		.warm_code   (thr_warm),
		.hot_code    (thr_hot),
		.monitor_off (ntc_off),
		.zone        (zone),
		.crossing    (zone_cross)
	);

	wire logic temp_block = (zone == ZONE_COLD_HOT) || (charger_config && zone == ZONE_WARM);

	// die hysteresis; lower code is hotter
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			die_hot <= 1'b0;
		else if (die_code <= die_stop)
			die_hot <= 1'b1;
		else if (die_code >= die_resume)
			die_hot <= 1'b0;
	end

	wire logic [MV_W-1:0] vterm = (zone == ZONE_WARM) ? warm_term_voltage : term_voltage;
	wire logic [MV_W+6:0] vterm_scaled = 20'(vterm) * 20'(RECHARGE_PCT);
	wire logic [MV_W+6:0] vbat_scaled  = 20'(battery_mv) * 20'd100;
	wire logic            below_recharge = vbat_scaled < vterm_scaled;

	// ------------------------------------------------------------
	// Charge current per phase
	// ------------------------------------------------------------
	// half in cool zone
	wire logic [CW-1:0] zone_current =
		(zone == ZONE_COOL && !cool_full_current) ? (current_live >> 1) : current_live;
	wire logic [CW-1:0] tenth_current = CW'(current_live / 10);
	wire logic [CW+1:0] term_current = term_current_20 ? (CW+2)'(current_live / 5) :
	                                                     (CW+2)'(tenth_current);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	wire logic ready = enabled && supply_present;
	wire logic retry_due = retry_count >= RETRY_TICKS - 1;

	always_comb begin
		next_state = charge_state;
		case (charge_state)
			ST_IDLE:
				if (ready)
					next_state = ST_DETECT;
			ST_DETECT:
				if (!ready)
					next_state = ST_IDLE;
				else if (battery_sensed && !undervoltage_lockout)
					next_state = ST_TRICKLE;
			ST_TRICKLE:
				if (!ready)
					next_state = ST_IDLE;
				else if (64'(timer) >= TRICKLE_TICKS - 1)
					next_state = ST_ERROR;
				else if (battery_mv > trickle_exit)
					next_state = ST_CC;
			ST_CC:
				if (!ready)
					next_state = ST_IDLE;
				else if (64'(timer) >= SAFETY_TICKS - 1)
					next_state = ST_ERROR;
				else if (battery_mv >= vterm)
					next_state = ST_CV;
			ST_CV:
				if (!ready)
					next_state = ST_IDLE;
				else if (battery_current < term_current && !temp_block && !die_hot)
					next_state = ST_DONE;
			ST_DONE:
				if (!ready)
					next_state = ST_IDLE;
				else if (below_recharge && !recharge_off)
					next_state = ST_TRICKLE;
			ST_ERROR:
				if (release_error || !supply_present)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			charge_state <= ST_IDLE;
		else
			charge_state <= next_state;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			retry_count <= 32'h0;
		else if (charge_state != ST_DETECT || retry_due)
			retry_count <= 32'h0;
		else
			retry_count <= retry_count + 32'h1;
	end

	// Trickle and safety timers share one counter; pauses do not stop it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			timer <= 64'h0;
		else if (next_state != charge_state || clear_safety_timer)
			timer <= 64'h0;
		else if (charge_state == ST_TRICKLE || charge_state == ST_CC)
			timer <= timer + 64'h1;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	wire logic in_charge = charge_state == ST_TRICKLE || charge_state == ST_CC ||
	                       charge_state == ST_CV;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			charge_on           <= 1'b0;
			charge_current_code <= '0;
			target_voltage      <= '0;
			release_attempt     <= 1'b0;
			battery_present     <= 1'b0;
			die_temp_status_a   <= 1'b0;
			charging_active     <= 1'b0;
			charge_error        <= 1'b0;
			temp_event          <= 1'b0;
			recharge_event      <= 1'b0;
			die_event           <= 1'b0;
			done_event          <= 1'b0;
		end else begin
			charge_on           <= in_charge && !temp_block && !die_hot;
			charge_current_code <= (charge_state == ST_TRICKLE) ? tenth_current : zone_current;
			target_voltage      <= vterm;
			release_attempt     <= charge_state == ST_DETECT && retry_due;
			battery_present     <= battery_sensed && !undervoltage_lockout;
			die_temp_status_a   <= die_hot;
			charging_active     <= in_charge;
			charge_error        <= next_state == ST_ERROR;
			temp_event          <= zone_cross && !ntc_off;
			recharge_event      <= charge_state == ST_DONE && next_state == ST_TRICKLE;
			die_event           <= die_code <= die_stop && !die_hot && in_charge;
			done_event          <= charge_state == ST_CV && next_state == ST_DONE;
		end
	end
endmodule
`default_nettype wire

// File: sim/charger_props.sv
// Port checker for the battery charge controller.
// Assumes reset thresholds stay in force: no threshold writes during a run.
`timescale 1ns/10ps
`default_nettype none
module charger_props
	import charger_pkg::*;
#(
	parameter int RETRY_TICKS = RETRY_CYCLES
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire logic              supply_present,
	input wire logic              battery_sensed,
	input wire logic [MV_W-1:0]   battery_mv,
	input wire logic [MV_W-1:0]   term_voltage,
	input wire logic [CODE_W-1:0] die_code,
	input wire logic              charge_on,
	input wire logic              release_attempt,
	input wire logic              battery_present,
	input wire logic              die_temp_status_a,
	input wire logic              charge_error,
	input wire charge_state_t     charge_state
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Cycles since the last release attempt, zero outside detection.
	logic [31:0] gap;
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			gap <= '0;
		else if (release_attempt)
			gap <= 32'h1;
		else if (charge_state == ST_DETECT && gap != 0)
			gap <= gap + 32'h1;
		else
			gap <= '0;
	end

	property p_idle_hold;
		charge_state == ST_IDLE && !supply_present |=> charge_state == ST_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("left idle without supply");
	property p_cc_entry;
		$rose(charge_state == ST_CC) |->
			$past(charge_state) == ST_TRICKLE && $past(battery_mv) > TRICKLE_EXIT_RESET;
	endproperty
	a_cc_entry: assert property (p_cc_entry) else $error("bad entry to constant current");
	property p_cv_entry;
		$rose(charge_state == ST_CV) |-> $past(battery_mv) >= $past(term_voltage);
	endproperty
	a_cv_entry: assert property (p_cv_entry) else $error("constant voltage too early");
	property p_done_entry;
		$rose(charge_state == ST_DONE) |-> $past(charge_state) == ST_CV;
	endproperty
	a_done_entry: assert property (p_done_entry) else $error("done not from cv");
	property p_hold_done;
		charge_state == ST_DONE && 32'(battery_mv) * 100 >= 32'(term_voltage) * 95
			|=> charge_state inside {ST_DONE, ST_IDLE, ST_ERROR};
	endproperty
	a_hold_done: assert property (p_hold_done) else $error("recharge above threshold");
	property p_retry;
		release_attempt && gap != 0 |-> gap == RETRY_TICKS;
	endproperty
	a_retry: assert property (p_retry) else $error("release retry spacing wrong");
	property p_absent;
		(!battery_sensed) [*3] |-> !battery_present;
	endproperty
	a_absent: assert property (p_absent) else $error("battery shown present");
	property p_reset;
		$fell(rst) |-> charge_state == ST_IDLE && !charge_on;
	endproperty
	a_reset: assert property (p_reset) else $error("not idle after reset");
	property p_die_stop;
		(die_code <= DIE_STOP_RESET) [*3] |-> die_temp_status_a && !charge_on;
	endproperty
	a_die_stop: assert property (p_die_stop) else $error("die hot but charging");
	property p_error_off;
		charge_error [*2] |-> !charge_on;
	endproperty
	a_error_off: assert property (p_error_off) else $error("charging in error");

	c_done: cover property (charge_state == ST_DONE);
	c_retry: cover property (release_attempt && gap != 0);
	c_die: cover property (die_temp_status_a);
	c_error: cover property (charge_error);
endmodule

bind battery_charge_controller charger_props #(.RETRY_TICKS(RETRY_TICKS)) charger_props_inst (
	.clock(clock), .rst(rst), .supply_present(supply_present),
	.battery_sensed(battery_sensed), .battery_mv(battery_mv), .term_voltage(term_voltage),
	.die_code(die_code), .charge_on(charge_on), .release_attempt(release_attempt),
	.battery_present(battery_present), .die_temp_status_a(die_temp_status_a),
	.charge_error(charge_error), .charge_state(charge_state));
`default_nettype wire

// File: sim/battery_pack.sv
// Behavioural battery pack with protection circuit and a slow cell.
// Assumes the charger drives charge_on and the applied current code.
`timescale 1ns/10ps
`default_nettype none
module battery_pack (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        charge_on,
	input  wire logic [8:0]  charge_current_code,
	input  wire logic [12:0] target_voltage,
	input  wire logic        release_attempt,
	input  wire logic        fitted,
	input  wire logic        drain,
	input  wire logic [1:0]  fails,
	output logic             battery_sensed,
	output logic             undervoltage_lockout,
	output logic [12:0]      battery_mv,
	output logic [10:0]      battery_current
);
	logic [1:0] releases;
	assign battery_sensed = fitted;
	// lockout release
	// The pack ignores the first attempts, so the charger must retry.
	assign undervoltage_lockout = releases < fails;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			releases <= 2'h0;
			battery_mv <= 13'h0af0;
			battery_current <= 11'h000;
		end else begin
			if (release_attempt && releases != 2'h3)
				releases <= releases + 2'h1;
			// A drained cell falls even while charged, which forces timeouts.
			if (drain)
				battery_mv <= battery_mv - 13'h0004;
			else if (charge_on && battery_mv < target_voltage)
				battery_mv <= battery_mv + 13'h0002;
			if (!charge_on)
				battery_current <= 11'h000;
			else if (battery_mv < target_voltage)
				battery_current <= {2'h0, charge_current_code};
			else if (battery_current > 11'h004)
				battery_current <= battery_current - 11'h004;
			else
				battery_current <= 11'h000;
		end
	end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the charge controller with a battery pack model.
// Assumes short retry and timeout counts; thresholds stay at reset values.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import charger_pkg::*;
;
	logic clock, rst, recharge_disable_in, ntc_disable_in, charger_config, cool_full_current;
	logic [8:0] strb;
	logic [7:0] charge_current_high;
	logic charge_current_low, supply_present, fitted, drain, term_current_20;
	logic [12:0] term_voltage, warm_term_voltage, battery_mv, trickle_exit_voltage;
	logic [9:0] ntc_code, die_code, ntc_thr_cold, ntc_thr_cool, ntc_thr_warm, ntc_thr_hot;
	logic [9:0] die_stop_temp, die_resume_temp;
	logic [1:0] fails;
	logic [10:0] battery_current;
	logic battery_sensed, undervoltage_lockout, charge_on, release_attempt, battery_present;
	logic die_temp_status_a, charging_active, charge_error;
	logic temp_event, recharge_event, die_event, done_event;
	logic [8:0] charge_current_code;
	logic [12:0] target_voltage;
	charge_state_t charge_state;
	int miscompares, tests_run, cycles, attempts;
	logic tev, rev, dev, hev;

	battery_charge_controller #(.RETRY_TICKS(20), .TRICKLE_TICKS(100), .SAFETY_TICKS(60000))
	battery_charge_controller_inst (
		.clock(clock), .rst(rst), .charge_enable_set(strb[0]), .charge_enable_clear(strb[1]),
		.feature_disable_set(strb[2]), .recharge_disable_in(recharge_disable_in),
		.ntc_disable_in(ntc_disable_in), .release_error(strb[3]),
		.clear_safety_timer(strb[4]), .charger_config(charger_config),
		.cool_full_current(cool_full_current), .term_current_20(term_current_20),
		.charge_current_high(charge_current_high), .charge_current_low(charge_current_low),
		.current_write(strb[5]), .term_voltage(term_voltage),
		.warm_term_voltage(warm_term_voltage), .trickle_exit_voltage(trickle_exit_voltage),
		.trickle_exit_write(strb[6]), .ntc_thr_cold(ntc_thr_cold), .ntc_thr_cool(ntc_thr_cool),
		.ntc_thr_warm(ntc_thr_warm), .ntc_thr_hot(ntc_thr_hot), .ntc_thr_write(strb[7]),
		.die_stop_temp(die_stop_temp), .die_resume_temp(die_resume_temp),
		.die_thr_write(strb[8]),
		.supply_present(supply_present), .battery_sensed(battery_sensed),
		.undervoltage_lockout(undervoltage_lockout), .battery_mv(battery_mv),
		.battery_current(battery_current), .ntc_code(ntc_code), .die_code(die_code),
		.charge_on(charge_on), .charge_current_code(charge_current_code),
		.target_voltage(target_voltage), .release_attempt(release_attempt),
		.battery_present(battery_present), .die_temp_status_a(die_temp_status_a),
		.charging_active(charging_active), .charge_error(charge_error),
		.charge_state(charge_state), .temp_event(temp_event),
		.recharge_event(recharge_event), .die_event(die_event), .done_event(done_event));

	battery_pack battery_pack_inst (
		.clock(clock), .rst(rst), .charge_on(charge_on),
		.charge_current_code(charge_current_code), .target_voltage(target_voltage),
		.release_attempt(release_attempt), .fitted(fitted), .drain(drain), .fails(fails),
		.battery_sensed(battery_sensed), .undervoltage_lockout(undervoltage_lockout),
		.battery_mv(battery_mv), .battery_current(battery_current));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		attempts += int'(release_attempt === 1'b1);
		tev |= (temp_event === 1'b1);
		rev |= (recharge_event === 1'b1);
		dev |= (done_event === 1'b1);
		hev |= (die_event === 1'b1);
		// A hang counts as a failure rather than running forever.
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	task tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task pulse(input int k);
		strb[k] = 1'b1;
		tick(1);
		strb[k] = 1'b0;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wait_state(input charge_state_t s);
		int n;
		n = 0;
		while (charge_state !== s && n < 400) begin
			tick(1);
			n++;
		end
		chk(charge_state, s);
	endtask

	task give_verdict();
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1; strb = 9'h000; recharge_disable_in = 1'b0; ntc_disable_in = 1'b0;
		charger_config = 1'b0; cool_full_current = 1'b0; charge_current_high = 8'h32;
		charge_current_low = 1'b1; supply_present = 1'b0; fitted = 1'b0; drain = 1'b0;
		term_voltage = 13'h0bb8; warm_term_voltage = 13'h0c80; ntc_code = 10'h1f4;
		die_code = 10'h1f4; miscompares = 0; tests_run = 0; cycles = 0; attempts = 0;
		tev = 1'b0; rev = 1'b0; dev = 1'b0; hev = 1'b0; term_current_20 = 1'b1; fails = 2'h2;
		trickle_exit_voltage = TRICKLE_EXIT_RESET; ntc_thr_cold = NTC_COLD_RESET;
		ntc_thr_cool = NTC_COOL_RESET; ntc_thr_warm = NTC_WARM_RESET; ntc_thr_hot = NTC_HOT_RESET;
		die_stop_temp = DIE_STOP_RESET; die_resume_temp = DIE_RESUME_RESET;
		tick(6);
		rst = 1'b0;
		tick(1);
		chk({charge_state, charge_on}, {ST_IDLE, 1'b0});
		pulse(4);
		pulse(5);
		pulse(6);
		pulse(7);
		pulse(8);
		pulse(0);
		tick(10);
		chk(charge_on, 1'b0);
		chk(battery_present, 1'b0);
		supply_present = 1'b1;
		fitted = 1'b1;
		wait_state(ST_TRICKLE);
		chk(attempts, 2);
		tick(2);
		chk({charge_on, charging_active, battery_present, charge_current_code}, {3'b111, 9'h00a});
		wait_state(ST_CC);
		tick(2);
		chk(charge_current_code, 9'h065);
		charge_current_high = 8'h08;
		charge_current_low = 1'b0;
		pulse(5);
		tick(3);
		chk(charge_current_code, 9'h065);
		ntc_code = 10'h2bc;
		tick(3);
		chk(charge_current_code, 9'h032);
		cool_full_current = 1'b1;
		tick(3);
		chk(charge_current_code, 9'h065);
		ntc_code = 10'h1f4;
		die_code = 10'h15e;
		tick(4);
		chk({charge_on, die_temp_status_a, hev}, 3'b011);
		die_code = 10'h17c;
		tick(4);
		chk(charge_on, 1'b1);
		ntc_code = 10'h12c;
		tick(3);
		chk(target_voltage, warm_term_voltage);
		charger_config = 1'b1;
		tick(3);
		chk(charge_on, 1'b0);
		charger_config = 1'b0;
		ntc_disable_in = 1'b1;
		tev = 1'b0;
		pulse(2);
		ntc_code = 10'h320;
		tick(4);
		chk({charge_on, tev}, 2'b10);
		ntc_disable_in = 1'b0;
		pulse(2);
		tick(4);
		chk({charge_on, tev}, 2'b01);
		ntc_code = 10'h1f4;
		wait_state(ST_CV);
		chk(target_voltage, term_voltage);
		wait_state(ST_DONE);
		chk(battery_current, 11'h00d);
		tick(1);
		chk(dev, 1'b1);
		drain = 1'b1;
		while (battery_mv > 13'h0b24) begin
			chk(charge_state, ST_DONE);
			tick(1);
		end
		wait_state(ST_TRICKLE);
		tick(1);
		chk(rev, 1'b1);
		wait_state(ST_ERROR);
		tick(2);
		chk({charge_error, charge_on, charging_active}, 3'b100);
		drain = 1'b0;
		pulse(3);
		tick(2);
		chk(charge_state, ST_IDLE);
		give_verdict();
	end
endmodule
`default_nettype wire
